// [shared/hspc_cfg.svh]
// register indices, field positions and reset values of the high speed pulse counter
`ifndef HSPC_CFG_SVH
`define HSPC_CFG_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define HSPC_IDX_T0_CTRL 16'hFE10
`define HSPC_IDX_T0_LCNT 16'hFE12
`define HSPC_IDX_T0_HCNT 16'hFE13
`define HSPC_IDX_T0_LMAT 16'hFE14
`define HSPC_IDX_T0_HMAT 16'hFE15
`define HSPC_IDX_T0_LCAP 16'hFE16
`define HSPC_IDX_T0_HCAP 16'hFE17
`define HSPC_IDX_P1_TEST 16'hFE47
`define HSPC_IDX_IRQ01 16'hFE5D
`define HSPC_IDX_IRQ23 16'hFE5E
`define HSPC_IDX_INSEL 16'hFE5F
`define HSPC_IDX_FC_CTRL 16'hFE7D
`define HSPC_IDX_RT_PORT 16'hFE80

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define HSPC_T0_HRUN 7
`define HSPC_T0_LRUN 6
`define HSPC_T0_LONG 5
`define HSPC_T0_LEXT 4
`define HSPC_T0_HFLAG 3
`define HSPC_T0_HIE 2
`define HSPC_T0_LFLAG 1
`define HSPC_T0_LIE 0
`define HSPC_FC_EN 7
`define HSPC_FC_CMP_LSB 4
`define HSPC_TST_DIS 2
`define HSPC_RT_LEVEL 7
`define HSPC_RT_DIR 6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define HSPC_RST_BYTE 8'h00
`define HSPC_RST_FINE 3'h0

`endif

// [shared/hspc_pkg.sv]
// types of the high speed pulse counter
package hspc_pkg;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } hspc_ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } hspc_ahb_rsp_t;

    typedef struct packed {
        logic [1:0] cnt_sync;
        logic cnt_prev;
        logic [1:0] cap_sync;
        logic cap_prev;
        logic [7:0] t0_ctrl;
        logic [7:0] low_cnt;
        logic [7:0] high_cnt;
        logic [7:0] low_match;
        logic [7:0] high_match;
        logic [7:0] low_cap;
        logic [7:0] high_cap;
        logic [7:0] test_ctrl;
        logic [7:0] irq01;
        logic [7:0] irq23;
        logic [7:0] insel;
        logic fc_en;
        logic [2:0] fc_cmp;
        logic [3:0] fc_cap;
        logic [2:0] fine_cnt;
        logic armed;
        logic [7:0] rt_port;
        logic rt_pin;
        logic rt_oe;
        logic irq_low;
        logic irq_high;
        logic wr_pend;
        logic [15:0] wr_idx;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } hspc_state_t;

endpackage

// [rtl/hspc_top.sv]
// high speed pulse counter coupled to timer 0, with real-time output and capture
`timescale 1ns/10ps
`include "hspc_cfg.svh"

module hspc_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register bus
    input wire hspc_pkg::hspc_ahb_req_t ahb_req,
    output hspc_pkg::hspc_ahb_rsp_t ahb_rsp,
    // pins
    input wire logic fast_count_input,
    input wire logic capture_input,
    output logic rt_out,
    output logic rt_out_oe,
    // interrupt requests
    output logic irq_low_req,
    output logic irq_high_req
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // word aligned and inside the 18-bit byte window of the register space
    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a[31:18] == 14'h0);
    endfunction

    function automatic logic [7:0] reg_read(input hspc_pkg::hspc_state_t s,
                                            input logic [15:0] idx);
        case (idx)
            `HSPC_IDX_T0_CTRL: reg_read = s.t0_ctrl;
            `HSPC_IDX_T0_LCNT: reg_read = s.low_cnt;
            `HSPC_IDX_T0_HCNT: reg_read = s.high_cnt;
            `HSPC_IDX_T0_LMAT: reg_read = s.low_match;
            `HSPC_IDX_T0_HMAT: reg_read = s.high_match;
            `HSPC_IDX_T0_LCAP: reg_read = s.low_cap;
            `HSPC_IDX_T0_HCAP: reg_read = s.high_cap;
            `HSPC_IDX_P1_TEST: reg_read = s.test_ctrl;
            `HSPC_IDX_IRQ01: reg_read = s.irq01;
            `HSPC_IDX_IRQ23: reg_read = s.irq23;
            `HSPC_IDX_INSEL: reg_read = s.insel;
            `HSPC_IDX_FC_CTRL: reg_read = {s.fc_en, s.fc_cmp, s.fc_cap};
            `HSPC_IDX_RT_PORT: reg_read = s.rt_port;
            default: reg_read = 8'h00;
        endcase
    endfunction

    localparam hspc_pkg::hspc_state_t RST_STATE = '{
        t0_ctrl: `HSPC_RST_BYTE, low_cnt: `HSPC_RST_BYTE, high_cnt: `HSPC_RST_BYTE,
        low_match: `HSPC_RST_BYTE, high_match: `HSPC_RST_BYTE,
        fine_cnt: `HSPC_RST_FINE, hreadyout: 1'b1, default: '0};

    hspc_pkg::hspc_state_t s_reg;
    hspc_pkg::hspc_state_t s_next;

    logic cnt_edge;
    logic cap_edge;
    logic lrun;
    logic hrun;
    logic long_mode;
    logic lext;
    logic fine_step;
    logic fine_ovf;
    logic low_tick;
    logic low_hit;
    logic high_hit;
    logic nk_match;
    logic rt_active;
    logic take;
    logic wr;
    logic [7:0] wd;
    logic [15:0] cnt16;
    logic [11:0] cnt11;
    logic [11:0] tgt11;
    logic [19:0] cnt19;
    logic [19:0] tgt19;
    logic set_lflag;
    logic set_hflag;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // only the second stage of each synchroniser is looked at
        s_next.cnt_sync = {s_reg.cnt_sync[0], fast_count_input};
        s_next.cnt_prev = s_reg.cnt_sync[1];
        s_next.cap_sync = {s_reg.cap_sync[0], capture_input};
        s_next.cap_prev = s_reg.cap_sync[1];
        cnt_edge = s_reg.cnt_sync[1] & ~s_reg.cnt_prev;
        cap_edge = s_reg.cap_sync[1] & ~s_reg.cap_prev;

        lrun = s_reg.t0_ctrl[`HSPC_T0_LRUN];
        hrun = s_reg.t0_ctrl[`HSPC_T0_HRUN];
        long_mode = s_reg.t0_ctrl[`HSPC_T0_LONG];
        lext = s_reg.t0_ctrl[`HSPC_T0_LEXT];
        set_lflag = 1'b0;
        set_hflag = 1'b0;

        // fine counter steps only with low byte running on the external clock
        fine_step = s_reg.fc_en & lrun & lext & cnt_edge;
        fine_ovf = fine_step & (s_reg.fine_cnt == 3'h7);
        if (!s_reg.fc_en) begin
            s_next.fine_cnt = `HSPC_RST_FINE;
        end else if (fine_step) begin
            s_next.fine_cnt = s_reg.fine_cnt + 3'h1;
        end

        // low byte clock: fine overflow when coupled, else pin edge or every core clock
        if (s_reg.fc_en) begin
            low_tick = lrun & fine_ovf;
        end else begin
            low_tick = lrun & (lext ? cnt_edge : 1'b1);
        end

        // ---- timer 0 counters; the low byte, or the 16-bit pair in long mode, free running while coupled
        cnt16 = {s_reg.high_cnt, s_reg.low_cnt};
        low_hit = s_reg.low_cnt == s_reg.low_match;
        high_hit = s_reg.high_cnt == s_reg.high_match;
        if (long_mode) begin
            if (!lrun) begin
                s_next.low_cnt = 8'h00;
                s_next.high_cnt = 8'h00;
            end else if (low_tick) begin
                if (!s_reg.fc_en && low_hit && high_hit) begin
                    s_next.low_cnt = 8'h00;
                    s_next.high_cnt = 8'h00;
                    set_lflag = 1'b1;
                    set_hflag = 1'b1;
                end else begin
                    {s_next.high_cnt, s_next.low_cnt} = cnt16 + 16'h0001;
                end
            end
        end else begin
            if (!lrun) begin
                s_next.low_cnt = 8'h00;
            end else if (low_tick) begin
                if (!s_reg.fc_en && low_hit) begin
                    s_next.low_cnt = 8'h00;
                    set_lflag = 1'b1;
                end else begin
                    s_next.low_cnt = s_reg.low_cnt + 8'h01;
                end
            end
            // high byte keeps its ordinary timer behaviour in this mode
            if (!hrun) begin
                s_next.high_cnt = 8'h00;
            end else if (high_hit) begin
                s_next.high_cnt = 8'h00;
                set_hflag = 1'b1;
            end else begin
                s_next.high_cnt = s_reg.high_cnt + 8'h01;
            end
        end

        // ---- combined compare: target is {match + 1, fine compare}
        cnt11 = {1'b0, s_reg.low_cnt, s_reg.fine_cnt};
        tgt11 = {({1'b0, s_reg.low_match} + 9'h001), s_reg.fc_cmp};
        cnt19 = {1'b0, cnt16, s_reg.fine_cnt};
        tgt19 = {({1'b0, s_reg.high_match, s_reg.low_match} + 17'h00001), s_reg.fc_cmp};
        nk_match = s_reg.armed & s_reg.fc_en & (long_mode ? (cnt19 == tgt19)
                                                          : (cnt11 == tgt11));
        if (nk_match) begin
            set_lflag = 1'b1;
            set_hflag = set_hflag | long_mode;
            s_next.armed = 1'b0;
        end

        // ---- real-time output pin
        rt_active = s_reg.fc_en & ~s_reg.test_ctrl[`HSPC_TST_DIS] & s_reg.armed;
        // the latch level goes out at the edge that ends the match cycle
        if (rt_active && !nk_match) begin
            s_next.rt_pin = s_reg.rt_pin;
        end else begin
            s_next.rt_pin = s_reg.rt_port[`HSPC_RT_LEVEL];
        end
        s_next.rt_oe = s_reg.rt_port[`HSPC_RT_DIR];

        // ---- capture together with the low byte capture
        if (cap_edge) begin
            s_next.low_cap = s_reg.low_cnt;
            s_next.high_cap = s_reg.high_cnt;
            // carry marks a fine overflow not yet seen in the captured low byte
            s_next.fc_cap = {fine_ovf, s_next.fine_cnt};
        end

        // ---- bus: address phase decode, write applied in the data phase
        take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        wr = s_reg.wr_pend;
        wd = ahb_req.hwdata[7:0];
        s_next.wr_pend = take & ahb_req.hwrite & addr_ok(ahb_req.haddr);
        s_next.wr_idx = ahb_req.haddr[17:2];
        s_next.hrdata = 32'h0000_0000;
        if (take && !ahb_req.hwrite && addr_ok(ahb_req.haddr)) begin
            s_next.hrdata = {24'h00_0000, reg_read(s_reg, ahb_req.haddr[17:2])};
        end
        s_next.hreadyout = 1'b1;
        s_next.hresp = 1'b0;

        // flags: a hardware set wins over a software clear in the same cycle
        s_next.t0_ctrl[`HSPC_T0_LFLAG] = s_reg.t0_ctrl[`HSPC_T0_LFLAG];
        s_next.t0_ctrl[`HSPC_T0_HFLAG] = s_reg.t0_ctrl[`HSPC_T0_HFLAG];
        if (wr) begin
            case (s_reg.wr_idx)
                `HSPC_IDX_T0_CTRL: s_next.t0_ctrl = wd;
                `HSPC_IDX_T0_LMAT: s_next.low_match = wd;
                `HSPC_IDX_T0_HMAT: s_next.high_match = wd;
                `HSPC_IDX_P1_TEST: s_next.test_ctrl = wd;
                `HSPC_IDX_IRQ01: s_next.irq01 = wd;
                `HSPC_IDX_IRQ23: s_next.irq23 = wd;
                `HSPC_IDX_INSEL: s_next.insel = wd;
                `HSPC_IDX_RT_PORT: s_next.rt_port = wd;
                `HSPC_IDX_FC_CTRL: begin
                    s_next.fc_en = wd[`HSPC_FC_EN];
                    s_next.fc_cmp = wd[`HSPC_FC_CMP_LSB +: 3];
                    // capture bits are left alone
                    s_next.armed = wd[`HSPC_FC_EN];
                end
                default: begin
                end
            endcase
        end
        if (set_lflag) begin
            s_next.t0_ctrl[`HSPC_T0_LFLAG] = 1'b1;
        end
        if (set_hflag) begin
            s_next.t0_ctrl[`HSPC_T0_HFLAG] = 1'b1;
        end

        // interrupt requests from flag and enable
        s_next.irq_low = s_next.t0_ctrl[`HSPC_T0_LFLAG]
                       & s_next.t0_ctrl[`HSPC_T0_LIE];
        s_next.irq_high = s_next.t0_ctrl[`HSPC_T0_HFLAG]
                        & s_next.t0_ctrl[`HSPC_T0_HIE];
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ahb_rsp.hreadyout = s_reg.hreadyout;
    assign ahb_rsp.hresp = s_reg.hresp;
    assign ahb_rsp.hrdata = s_reg.hrdata;
    assign rt_out = s_reg.rt_pin;
    assign rt_out_oe = s_reg.rt_oe;
    assign irq_low_req = s_reg.irq_low;
    assign irq_high_req = s_reg.irq_high;

endmodule

// [bench/hspc_pulse_src.sv]
// far-side model: source of count pulses for the fast counter input
`timescale 1ns/10ps

module hspc_pulse_src (
    // clock
    input wire logic core_clk,
    // request from the bench
    input wire logic go,
    input wire logic [7:0] pulses,
    // far side pin and status
    output logic pulse,
    output logic busy
);
    logic [7:0] left = 8'h00;
    logic [2:0] ph = 3'h0;

    // three cycles high, three low: the input synchroniser needs two of each
    always @(posedge core_clk) begin
        if (go) begin
            left <= pulses;
            ph <= 3'h0;
        end else if (left != 8'h00) begin
            ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            if (ph == 3'h5)
                left <= left - 8'h01;
        end
    end
    assign pulse = (left != 8'h00) && (ph < 3'h3);
    assign busy = left != 8'h00;
endmodule

// [bench/hspc_properties.sv]
// assertions on the pins and bus of the high speed pulse counter
`timescale 1ns/10ps
`include "hspc_cfg.svh"

module hspc_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register bus
    input wire hspc_pkg::hspc_ahb_req_t ahb_req,
    input wire hspc_pkg::hspc_ahb_rsp_t ahb_rsp,
    // pins
    input wire logic fast_count_input,
    input wire logic capture_input,
    input wire logic rt_out,
    input wire logic rt_out_oe,
    input wire logic irq_low_req,
    input wire logic irq_high_req
);
    localparam logic [31:0] A_T0 = 32'(`HSPC_IDX_T0_CTRL) << 2;
    localparam logic [31:0] A_FC = 32'(`HSPC_IDX_FC_CTRL) << 2;
    localparam logic [31:0] A_TS = 32'(`HSPC_IDX_P1_TEST) << 2;
    localparam logic [31:0] A_RT = 32'(`HSPC_IDX_RT_PORT) << 2;
    logic take, wr_p, rd_p, rd_fc, lat, dir, en, dis, ie_l, ie_h, fol;
    logic [2:0] cmp;
    logic [31:0] wa;
    logic [7:0] wd;

    // shadow of the control bits, updated at the edge where a write lands
    assign take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    assign wd = ahb_req.hwdata[7:0];
    assign fol = !en || dis;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            {wr_p, rd_p, rd_fc, lat, dir, en, dis, ie_l, ie_h, cmp} <= '0;
        end else begin
            wr_p <= take && ahb_req.hwrite;
            rd_p <= take && !ahb_req.hwrite;
            rd_fc <= take && !ahb_req.hwrite && ahb_req.haddr == A_FC;
            if (wr_p && wa == A_RT)
                {lat, dir} <= wd[7:6];
            if (wr_p && wa == A_FC)
                {en, cmp} <= wd[7:4];
            if (wr_p && wa == A_TS)
                dis <= wd[2];
            if (wr_p && wa == A_T0)
                {ie_h, ie_l} <= {wd[2], wd[0]};
        end
        wa <= ahb_req.haddr;
    end

    // ----
    // assertions
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_BUS_OKAY: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
        else $error("bus answer not ready or not okay");
    AST_RDATA_IDLE: assert property (!rd_p |-> ahb_rsp.hrdata == 32'h0)
        else $error("read data outside a read data phase");
    AST_RDATA_UPPER: assert property (rd_p |-> ahb_rsp.hrdata[31:8] == 24'h0)
        else $error("upper read data lanes not zero");
    AST_FOLLOW_LATCH: assert property (fol && $past(fol) |-> rt_out == $past(lat))
        else $error("output pin does not follow the port latch");
    AST_OE_DIR: assert property (rt_out_oe == $past(dir))
        else $error("output enable differs from the pin direction");
    AST_IRQ_LOW_MASK: assert property (!ie_l && !$past(ie_l) |-> !irq_low_req)
        else $error("low interrupt raised while masked");
    AST_IRQ_HIGH_MASK: assert property (!ie_h && !$past(ie_h) |-> !irq_high_req)
        else $error("high interrupt raised while masked");
    AST_FC_READ: assert property (rd_fc |-> ahb_rsp.hrdata[7:4] == {$past(en), $past(cmp)})
        else $error("fast counter control reads back wrong");

    cover property ($fell(rt_out) && en);
    cover property ($rose(irq_low_req));
    cover property ($rose(irq_high_req));
endmodule

bind hspc_top hspc_checker hspc_checker_inst (
    .core_clk(core_clk), .nrst(nrst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .fast_count_input(fast_count_input), .capture_input(capture_input),
    .rt_out(rt_out), .rt_out_oe(rt_out_oe),
    .irq_low_req(irq_low_req), .irq_high_req(irq_high_req)
);

// [bench/tb.sv]
// self-checking bench of the high speed pulse counter
`timescale 1ns/10ps
`include "hspc_cfg.svh"

module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    hspc_pkg::hspc_ahb_req_t mreq = '0;
    hspc_pkg::hspc_ahb_req_t ahb_req;
    hspc_pkg::hspc_ahb_rsp_t ahb_rsp;
    logic go = 1'b0;
    logic cap_in = 1'b0;
    logic [7:0] npulse = 8'h00;
    logic pin, busy, rt_out, rt_out_oe, irq_l, irq_h;
    int errors = 0;
    int checked = 0;

    always #10 core_clk = ~core_clk;
    always_comb begin
        ahb_req = mreq;
        ahb_req.hready = ahb_rsp.hreadyout;
    end

    hspc_top hspc_top_inst (.core_clk(core_clk), .nrst(nrst), .ahb_req(ahb_req),
        .ahb_rsp(ahb_rsp), .fast_count_input(pin), .capture_input(cap_in),
        .rt_out(rt_out), .rt_out_oe(rt_out_oe), .irq_low_req(irq_l), .irq_high_req(irq_h));
    hspc_pulse_src hspc_pulse_src_inst (.core_clk(core_clk), .go(go), .pulses(npulse),
        .pulse(pin), .busy(busy));

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d,
        output logic [7:0] r);
        mreq.hsel <= 1'b1;
        mreq.haddr <= 32'(i) << 2;
        mreq.htrans <= 2'b10;
        mreq.hwrite <= w;
        mreq.hsize <= 3'h2;
        do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
        mreq.hsel <= 1'b0;
        mreq.htrans <= 2'b00;
        mreq.hwdata <= 32'(d);
        do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
        r = ahb_rsp.hrdata[7:0];
    endtask

    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, i, d, x);
    endtask

    task automatic rc(input logic [15:0] i, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, i, 8'h00, x);
        chk(x, e);
    endtask

    // pulses must be counted and matched before the pins are looked at
    task automatic send(input logic [7:0] n);
        go <= 1'b1;
        npulse <= n;
        @(posedge core_clk);
        go <= 1'b0;
        do @(posedge core_clk); while (busy);
        repeat (4) @(posedge core_clk);
    endtask

    task automatic cap;
        cap_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        cap_in <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic rst;
        nrst <= 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_regs;
        logic [15:0] all[12] = '{`HSPC_IDX_T0_CTRL, `HSPC_IDX_T0_LCNT, `HSPC_IDX_T0_HCNT,
            `HSPC_IDX_T0_LMAT, `HSPC_IDX_T0_HMAT, `HSPC_IDX_P1_TEST, `HSPC_IDX_IRQ01,
            `HSPC_IDX_IRQ23, `HSPC_IDX_INSEL, `HSPC_IDX_FC_CTRL, `HSPC_IDX_RT_PORT, 16'h0100};
        logic [15:0] rw[5] = '{`HSPC_IDX_T0_LMAT, `HSPC_IDX_T0_HMAT, `HSPC_IDX_IRQ01,
            `HSPC_IDX_IRQ23, `HSPC_IDX_INSEL};
        logic [15:0] ro[3] = '{`HSPC_IDX_T0_LCNT, `HSPC_IDX_T0_HCNT, 16'h0100};
        foreach (all[k]) rc(all[k], 8'h00);
        foreach (rw[k]) begin
            wr(rw[k], 8'hA5);
            rc(rw[k], 8'hA5);
        end
        foreach (ro[k]) begin
            wr(ro[k], 8'h5A);
            rc(ro[k], 8'h00);
        end
        $display("register map done");
    endtask

    task automatic t_follow;
        wr(`HSPC_IDX_RT_PORT, 8'hC0);
        repeat (2) @(posedge core_clk);
        chk(8'({rt_out_oe, rt_out}), 8'h03);
        wr(`HSPC_IDX_RT_PORT, 8'h40);
        repeat (2) @(posedge core_clk);
        chk(8'({rt_out_oe, rt_out}), 8'h02);
        $display("latch follow done");
    endtask

    task automatic t_match8;
        logic [7:0] fc;
        logic [7:0] lc;
        rst();
        wr(`HSPC_IDX_RT_PORT, 8'hC0);
        wr(`HSPC_IDX_T0_LMAT, 8'h00);
        wr(`HSPC_IDX_FC_CTRL, 8'hB0);
        wr(`HSPC_IDX_T0_CTRL, 8'h51);
        wr(`HSPC_IDX_RT_PORT, 8'h40);
        send(8'h0A);
        chk(8'({irq_l, rt_out}), 8'h01);
        send(8'h01);
        chk(8'({irq_l, rt_out}), 8'h02);
        rc(`HSPC_IDX_T0_CTRL, 8'h53);
        rc(`HSPC_IDX_T0_LCNT, 8'h01);
        wr(`HSPC_IDX_RT_PORT, 8'hC0);
        repeat (2) @(posedge core_clk);
        chk(8'(rt_out), 8'h01);
        wr(`HSPC_IDX_T0_CTRL, 8'h51);
        // the request output is launched at the edge that ends the write
        @(posedge core_clk);
        chk(8'(irq_l), 8'h00);
        rc(`HSPC_IDX_T0_CTRL, 8'h51);
        cap();
        bus(1'b0, `HSPC_IDX_FC_CTRL, 8'h00, fc);
        chk(fc, 8'hB3);
        bus(1'b0, `HSPC_IDX_T0_LCAP, 8'h00, lc);
        chk(lc, 8'h01);
        // software view of the combined count: timer capture plus carry, then fine bits
        chk({lc[4:0] + {4'h0, fc[3]}, fc[2:0]}, 8'h0B);
        wr(`HSPC_IDX_FC_CTRL, 8'hBC);
        rc(`HSPC_IDX_FC_CTRL, 8'hB3);
        wr(`HSPC_IDX_FC_CTRL, 8'h00);
        wr(`HSPC_IDX_FC_CTRL, 8'h80);
        cap();
        rc(`HSPC_IDX_FC_CTRL, 8'h80);
        $display("eleven bit match done");
    endtask

    task automatic t_match16;
        rst();
        wr(`HSPC_IDX_FC_CTRL, 8'h90);
        wr(`HSPC_IDX_T0_CTRL, 8'hF4);
        send(8'h08);
        chk(8'({irq_h, irq_l}), 8'h00);
        send(8'h01);
        chk(8'({irq_h, irq_l}), 8'h02);
        rc(`HSPC_IDX_T0_CTRL, 8'hFE);
        rc(`HSPC_IDX_T0_LCNT, 8'h01);
        $display("nineteen bit match done");
    endtask

    task automatic t_disable;
        rst();
        wr(`HSPC_IDX_P1_TEST, 8'h04);
        wr(`HSPC_IDX_FC_CTRL, 8'h80);
        wr(`HSPC_IDX_RT_PORT, 8'hC0);
        repeat (2) @(posedge core_clk);
        chk(8'(rt_out), 8'h01);
        wr(`HSPC_IDX_P1_TEST, 8'h00);
        wr(`HSPC_IDX_FC_CTRL, 8'h80);
        wr(`HSPC_IDX_RT_PORT, 8'h40);
        repeat (2) @(posedge core_clk);
        chk(8'(rt_out), 8'h01);
        $display("output disable done");
    endtask

    initial begin
        rst();
        t_regs();
        t_follow();
        t_match8();
        t_match16();
        t_disable();
        give_verdict();
    end

    // the tests take about 340 cycles; 20000 leaves ample margin
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule
